// ---- design/dpsc_ctrl.sv ----
// Host-side controller driving one port of the dual-port memory
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_consts.svh"
module dpsc_ctrl #(
  parameter int SLAVE_MODE = 0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire dpsc_pkg::dpsc_req_t req,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic collision,
  output dpsc_pkg::dpsc_pins_t pins,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic busy_n
);
  typedef enum logic [2:0] {
    DPSC_IDLE, DPSC_RD, DPSC_WR_BUSY, DPSC_WR, DPSC_WR_END, DPSC_BUSY_WAIT
  } dpsc_state_t;

  function automatic logic [3:0] dpsc_max(input logic [3:0] a,
                                          input logic [3:0] b);
    dpsc_max = (a > b) ? a : b;
  endfunction : dpsc_max

  localparam logic [3:0] RD_CYC = 4'(dpsc_max(
    4'(`DPSC_CYC(`DPSC_READ_CYCLE_MIN_NS)),
    4'(`DPSC_CYC(`DPSC_ADDRESS_TO_DATA_MAX_NS))));
  localparam logic [3:0] WP_CYC = 4'(dpsc_max(
    4'(`DPSC_CYC(`DPSC_WRITE_PULSE_MIN_NS)),
    4'(`DPSC_CYC(`DPSC_WRITE_TO_HIGHZ_MAX_NS
      + `DPSC_DATA_SETUP_TO_WRITE_END_NS))));
  localparam logic [3:0] BAA_CYC =
    4'(`DPSC_CYC(`DPSC_BUSY_FROM_ADDRESS_MAX_NS));
  localparam logic [3:0] BDD_CYC =
    4'(`DPSC_CYC(`DPSC_BUSY_RELEASE_TO_DATA_NS));
  // Enables stay on until the data has crossed the synchroniser
  localparam logic [3:0] SYNC_CYC = 4'(`DPSC_SYNC_STAGES);
  // Busy passes the same synchroniser, so one edge more than the delay
  localparam logic [3:0] BDD_WAIT = BDD_CYC + 4'h1;

  logic rst_m, rst_s;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  logic busy_m, busy_s;
  logic [7:0] din_m, din_s;
  always_ff @(posedge sys_clk or negedge rst_s) begin
    if (!rst_s) begin
      busy_m <= 1'b1;
      busy_s <= 1'b1;
      din_m <= 8'h00;
      din_s <= 8'h00;
    end else begin
      busy_m <= busy_n;
      busy_s <= busy_m;
      din_m <= data_in;
      din_s <= din_m;
    end
  end

  dpsc_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  dpsc_pkg::dpsc_pins_t next_pins;
  logic [7:0] next_data_out, next_rsp_data;
  logic next_data_oe, next_rsp_valid, coll, next_coll;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pins = pins;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_rsp_data = rsp_data;
    next_rsp_valid = 1'b0;
    next_coll = coll;
    unique case (state)
      DPSC_IDLE: begin
        next_pins.select_n = 1'b1;
        next_pins.write_n = 1'b1;
        next_data_oe = 1'b0;
        if (req_valid) begin
          // Address changes only with select and strobe off
          next_pins.addr = req.addr;
          next_coll = collision;
          next_pins.select_n = 1'b0;
          if (req.write) begin
            next_pins.out_en_n = 1'b1;
            next_data_out = req.wdata;
            next_data_oe = 1'b1;
            next_state = (SLAVE_MODE != 0) ? DPSC_WR_BUSY : DPSC_WR;
            next_cnt = (SLAVE_MODE != 0) ? BAA_CYC : WP_CYC;
            next_pins.write_n = (SLAVE_MODE != 0);
          end else begin
            next_pins.out_en_n = 1'b0;
            next_state = DPSC_RD;
            next_cnt = RD_CYC + SYNC_CYC;
          end
        end
      end
      DPSC_RD: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          if (coll) begin
            next_state = DPSC_BUSY_WAIT;
            next_cnt = BDD_WAIT;
          end else begin
            // Busy ignored for plain reads
            next_rsp_data = din_s;
            next_rsp_valid = 1'b1;
            next_pins.select_n = 1'b1;
            next_pins.out_en_n = 1'b1;
            next_state = DPSC_IDLE;
          end
        end
      end
      DPSC_BUSY_WAIT: begin
        if (busy_s) begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_rsp_data = din_s;
            next_rsp_valid = 1'b1;
            next_pins.select_n = 1'b1;
            next_pins.out_en_n = 1'b1;
            next_state = DPSC_IDLE;
          end
        end else begin
          next_cnt = BDD_WAIT;
        end
      end
      DPSC_WR_BUSY: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_pins.write_n = 1'b0;
          next_cnt = WP_CYC;
          next_state = DPSC_WR;
        end
      end
      DPSC_WR: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_pins.write_n = 1'b1;
          next_pins.select_n = 1'b1;
          next_state = DPSC_WR_END;
        end
      end
      DPSC_WR_END: begin
        next_data_oe = 1'b0;
        next_state = DPSC_IDLE;
      end
      default: next_state = DPSC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_s) begin
    if (!rst_s) begin
      state <= DPSC_IDLE;
      cnt <= 4'h0;
      pins <= '{select_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1,
                addr: 11'h000};
      data_out <= 8'h00;
      data_oe <= 1'b0;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      coll <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      rsp_data <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
      coll <= next_coll;
    end
  end

  assign req_ready = (state == DPSC_IDLE);

  // Strobe low time, kept only for the pulse-width check
  logic [3:0] wr_low, next_wr_low;
  always_comb begin
    next_wr_low = pins.write_n ? 4'h0 : wr_low + 4'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_s) begin
    if (!rst_s) begin
      wr_low <= 4'h0;
    end else begin
      wr_low <= next_wr_low;
    end
  end

  AST_STROBE_NEEDS_SELECT: assert property (@(posedge sys_clk)
    disable iff (!rst_s) !pins.write_n |-> !pins.select_n)
    else $error("write strobe without select");
  AST_ADDR_QUIET: assert property (@(posedge sys_clk)
    disable iff (!rst_s) $changed(pins.addr) |->
    $past(pins.write_n) && $past(pins.select_n))
    else $error("address moved during write");
  AST_NO_WRITE_WITH_OE: assert property (@(posedge sys_clk)
    disable iff (!rst_s) !pins.write_n |-> pins.out_en_n)
    else $error("output enable active in write");
  AST_WRITE_PULSE: assert property (@(posedge sys_clk)
    disable iff (!rst_s) $rose(pins.write_n) |->
    (32'(wr_low) * `DPSC_CLK_PERIOD_NS >=
    `DPSC_WRITE_TO_HIGHZ_MAX_NS + `DPSC_DATA_SETUP_TO_WRITE_END_NS))
    else $error("write pulse too short");
  AST_DATA_HELD: assert property (@(posedge sys_clk)
    disable iff (!rst_s) !pins.write_n |->
    data_oe && ($fell(pins.write_n) || $stable(data_out)))
    else $error("write data not driven");
  AST_RELEASE_BUS: assert property (@(posedge sys_clk)
    disable iff (!rst_s) $rose(pins.select_n) && $past(!pins.write_n) |=>
    !data_oe)
    else $error("bus not released");
  AST_NO_FIGHT: assert property (@(posedge sys_clk)
    disable iff (!rst_s) data_oe |-> pins.out_en_n)
    else $error("data driven while port outputs enabled");
  AST_READ_SPACING: assert property (@(posedge sys_clk)
    disable iff (!rst_s) $rose(rsp_valid) |->
    !$past(pins.select_n, 3) && !$past(pins.select_n, 1) &&
    !$past(pins.out_en_n, 1))
    else $error("read answered too early");
  AST_READ_ENABLES: assert property (@(posedge sys_clk)
    disable iff (!rst_s) (state == DPSC_RD) |->
    !pins.out_en_n && pins.write_n && !pins.select_n)
    else $error("read enables wrong");
  CVR_READ: cover property (@(posedge sys_clk) disable iff (!rst_s)
    (state == DPSC_RD) ##1 rsp_valid);
  CVR_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_s)
    $rose(pins.write_n) && state == DPSC_WR_END);
  CVR_COLL: cover property (@(posedge sys_clk) disable iff (!rst_s)
    state == DPSC_BUSY_WAIT ##1 rsp_valid);
  CVR_SLAVE_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_s)
    state == DPSC_WR_BUSY ##1 !pins.write_n);
endmodule : dpsc_ctrl
`default_nettype wire

// ---- include/dpsc_consts.svh ----
// Timing constants for the dual-port memory port controller
`ifndef DPSC_CONSTS_SVH
`define DPSC_CONSTS_SVH
`define DPSC_CLK_PERIOD_NS 25
`define DPSC_READ_CYCLE_MIN_NS 20
`define DPSC_ADDRESS_TO_DATA_MAX_NS 20
`define DPSC_WRITE_CYCLE_MIN_NS 20
`define DPSC_WRITE_PULSE_MIN_NS 15
`define DPSC_WRITE_TO_HIGHZ_MAX_NS 10
`define DPSC_DATA_SETUP_TO_WRITE_END_NS 10
`define DPSC_BUSY_FROM_ADDRESS_MAX_NS 20
`define DPSC_BUSY_RELEASE_TO_DATA_NS 25
`define DPSC_SYNC_STAGES 2
`define DPSC_CYC(ns) (((ns) + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS)
`endif

// ---- include/dpsc_pkg.sv ----
// Types for the dual-port memory port controller
package dpsc_pkg;
  typedef struct packed {
    logic write;
    logic [10:0] addr;
    logic [7:0] wdata;
  } dpsc_req_t;
  typedef struct packed {
    logic select_n;
    logic write_n;
    logic out_en_n;
    logic [10:0] addr;
  } dpsc_pins_t;
endpackage : dpsc_pkg

// ---- tb/dpsc_mem_model.sv ----
// Behavioural model of one port of the dual-port memory
`timescale 1ns/1ps
`default_nettype none
module dpsc_mem_model (
  input wire dpsc_pkg::dpsc_pins_t pins,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [7:0] data_in,
  output logic clash
);
  logic [7:0] mem [0:2047];
  logic [7:0] rd;
  logic [7:0] last;
  logic on;
  // Outputs live only while selected, enabled and not writing
  assign on = !pins.select_n && !pins.out_en_n && pins.write_n;
  // Old data stays until the access delay has run out
  assign #20 rd = mem[pins.addr];
  always @(rd) last = rd;
  // Floating bus shows garbage, not the last value
  assign data_in = on ? rd : ~last;
  initial clash = 1'h0;
  always @(data_oe or on) if (data_oe && on) clash = 1'h1;
  always @(posedge (pins.select_n | pins.write_n)) begin
    if (data_oe) mem[pins.addr] = data_out;
  end
endmodule : dpsc_mem_model
`default_nettype wire

// ---- tb/dpsc_ctrl_test.sv ----
// Self-checking bench for the dual-port memory port controller
`timescale 1ns/1ps
`default_nettype none
module dpsc_ctrl_test;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic req_valid = 1'h0;
  logic collision = 1'h0;
  logic busy_n = 1'h1;
  dpsc_pkg::dpsc_req_t req = '0;
  logic req_ready, rsp_valid, data_oe, clash;
  logic [7:0] rsp_data, data_in, data_out, got;
  dpsc_pkg::dpsc_pins_t pins;
  int err_count = 0;
  int samples_checked = 0;
  logic [27:0] rows [8] = '{{1'h1, 11'h000, 8'hA5, 8'h00},
    {1'h1, 11'h7FF, 8'h5A, 8'h00}, {1'h1, 11'h123, 8'h3C, 8'h00},
    {1'h0, 11'h000, 8'h00, 8'hA5}, {1'h0, 11'h7FF, 8'h00, 8'h5A},
    {1'h0, 11'h123, 8'h00, 8'h3C}, {1'h1, 11'h123, 8'hC3, 8'h00},
    {1'h0, 11'h123, 8'h00, 8'hC3}};
  always #12.5 sys_clk = ~sys_clk;
  dpsc_ctrl dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .collision(collision),
    .pins(pins), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .busy_n(busy_n));
  dpsc_mem_model mem_u (.pins(pins), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .clash(clash));
  // Second port controller in slave mode, with its own memory port
  logic s_valid = 1'h0;
  logic s_ready, s_rspv, s_doe, s_clash;
  logic [7:0] s_rspd, s_din, s_dout;
  dpsc_pkg::dpsc_pins_t s_pins;
  dpsc_ctrl #(.SLAVE_MODE(1)) slv_u (.sys_clk(sys_clk), .resetn(resetn),
    .req_valid(s_valid), .req_ready(s_ready), .req(req),
    .rsp_valid(s_rspv), .rsp_data(s_rspd), .collision(collision),
    .pins(s_pins), .data_in(s_din), .data_out(s_dout),
    .data_oe(s_doe), .busy_n(busy_n));
  dpsc_mem_model smem_u (.pins(s_pins), .data_out(s_dout),
    .data_oe(s_doe), .data_in(s_din), .clash(s_clash));
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic fail(input string m);
    err_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) fail($sformatf("data %h expected %h", g, e));
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) fail($sformatf("flag %b expected %b", g, e));
  endtask : chk1
  task automatic xfer(input dpsc_pkg::dpsc_req_t r);
    int i;
    for (i = 0; i < 40 && req_ready !== 1'h1; i++) @(negedge sys_clk);
    if (i == 40) begin
      fail("ready timeout");
      final_report();
    end
    req = r;
    req_valid = 1'h1;
    @(negedge sys_clk);
    req_valid = 1'h0;
    chk1(pins.select_n, 1'h0);
    chk1(pins.write_n, ~r.write);
    chk1(pins.out_en_n, r.write);
    chk1(pins.addr === r.addr, 1'h1);
    chk1(data_oe, r.write);
    if (r.write) chk8(data_out, r.wdata);
    @(negedge sys_clk);
  endtask : xfer
  task automatic await_rsp(input int n);
    int i;
    for (i = 0; i < n && rsp_valid !== 1'h1; i++) @(negedge sys_clk);
    if (i == n) begin
      fail("response timeout");
      final_report();
    end
    got = rsp_data;
  endtask : await_rsp
  initial begin
    repeat (8) @(negedge sys_clk);
    chk1(pins.select_n, 1'h1);
    chk1(data_oe, 1'h0);
    repeat (8) @(negedge sys_clk);
    resetn = 1'h1;
    repeat (4) @(negedge sys_clk);
    foreach (rows[k]) begin
      xfer(rows[k][27:8]);
      if (!rows[k][27]) begin
        await_rsp(3);
        chk8(got, rows[k][7:0]);
      end
    end
    // Busy low without a collision must not hold the read back
    busy_n = 1'h0;
    xfer({1'h0, 11'h000, 8'h00});
    await_rsp(3);
    chk8(got, 8'hA5);
    collision = 1'h1;
    xfer({1'h0, 11'h7FF, 8'h00});
    repeat (4) begin
      chk1(rsp_valid, 1'h0);
      @(negedge sys_clk);
    end
    busy_n = 1'h1;
    await_rsp(8);
    chk8(got, 8'h5A);
    collision = 1'h0;
    // Slave mode: strobe falls only after the busy access time
    req = {1'h1, 11'h055, 8'h96};
    s_valid = 1'h1;
    @(negedge sys_clk);
    s_valid = 1'h0;
    chk1(s_pins.write_n, 1'h1);
    chk1(s_pins.select_n, 1'h0);
    chk1(s_doe, 1'h1);
    @(negedge sys_clk);
    chk1(s_pins.write_n, 1'h0);
    @(negedge sys_clk);
    chk1(s_pins.write_n, 1'h1);
    @(negedge sys_clk);
    req = {1'h0, 11'h055, 8'h00};
    s_valid = 1'h1;
    @(negedge sys_clk);
    s_valid = 1'h0;
    for (int j = 0; j < 6 && s_rspv !== 1'h1; j++) @(negedge sys_clk);
    chk1(s_rspv, 1'h1);
    chk8(s_rspd, 8'h96);
    chk1(s_clash, 1'h0);
    chk1(clash, 1'h0);
    final_report();
  end
endmodule : dpsc_ctrl_test
`default_nettype wire
